// ==== dv/lsci_host_asserts.sv ====
`timescale 1ns/1ps
module lsci_host_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Observed outputs
    input wire logic rdata_valid_q,
    input wire lsci_pkg::lsci_pins_t pins_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic sel_n;
    assign sel_n = pins_q.select_n;
    // ------------------------------------------------------------
    // Strobe order and widths
    // ------------------------------------------------------------
    addr_hold_a: assert property ($fell(sel_n) |=> ($stable(pins_q.addr)) [*4])
        else $error("address moved in hold time");
    low_width_a: assert property ($fell(sel_n) |-> (!sel_n) [*8] ##1 (!sel_n) [*4])
        else $error("select low too short");
    read_write_a: assert property ($fell(sel_n) && pins_q.write_n |->
        (pins_q.write_n) [*8] ##1 (pins_q.write_n) [*6])
        else $error("write strobe moved in read");
    prechg_a: assert property ($rose(sel_n) |-> sel_n [*5])
        else $error("select high too short");
    nested_a: assert property ($fell(sel_n) && !pins_q.write_n |-> !$past(pins_q.write_n))
        else $error("write strobe late");
    wr_rise_a: assert property ($rose(pins_q.write_n) |-> sel_n)
        else $error("write strobe rose first");
    data_setup_a: assert property ($rose(sel_n) && !pins_q.write_n |-> pins_q.dq_oe &&
        $past(pins_q.dq_oe, 5) && pins_q.dq_out == $past(pins_q.dq_out, 5))
        else $error("write data setup short");
    bus_free_a: assert property (pins_q.write_n && $past(pins_q.write_n) |-> !pins_q.dq_oe)
        else $error("data driven outside write");
    rd_end_a: assert property (rdata_valid_q |-> $rose(sel_n) && pins_q.write_n)
        else $error("read data at wrong time");
    rd_c: cover property (rdata_valid_q);
    wr_c: cover property ($fell(sel_n) && !pins_q.write_n);
    chain_c: cover property ($fell(sel_n) && !pins_q.write_n && !$past(pins_q.write_n, 6));
endmodule

// ==== dv/lsci_mem_model.sv ====
`timescale 1ns/1ps
module lsci_mem_model (
    // Strobes from the controller
    input wire lsci_pkg::lsci_pins_t pins,
    // Shared bus as the controller sees it
    output logic [lsci_pkg::DATA_W-1:0] dq_in
);
    // Static array, no refresh, so any pause is safe
    logic [lsci_pkg::DATA_W-1:0] mem [lsci_pkg::WORDS];
    logic [lsci_pkg::ADDR_W-1:0] lat = '0;
    logic [lsci_pkg::DATA_W-1:0] junk = 4'h5;
    logic valid = 1'b0;
    logic fault = 1'b0;
    wire logic drive = valid && pins.write_n && !pins.select_n;
    always #10 junk = ~junk;
    always @(negedge pins.select_n) begin
        lat = pins.addr;
        valid = 1'b0;
        // Just inside access time, clear of the sampling edge
        #119 valid = 1'b1;
    end
    always @(posedge pins.select_n) begin
        if (!pins.write_n) mem[lat] = dq_in;
        valid = 1'b0;
    end
    always @* if (drive && pins.dq_oe) fault = 1'b1;
    // Released bus shows a moving pattern, never a stale value
    assign dq_in = pins.dq_oe ? pins.dq_out : (drive ? mem[lat] : junk);
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    lsci_pkg::lsci_req_t req = '0;
    logic req_valid = 1'b0;
    logic req_ready;
    logic rdata_valid_q;
    logic [3:0] rdata_q;
    logic [3:0] dq_in;
    lsci_pkg::lsci_pins_t pins_q;
    int error_cnt = 0;
    int n_tests = 0;
    always #5 clk = ~clk;
    lsci_host i_dut (.clk(clk), .arst_n(arst_n), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rdata_q(rdata_q), .rdata_valid_q(rdata_valid_q),
        .pins_q(pins_q), .dq_in(dq_in));
    lsci_mem_model i_mem (.pins(pins_q), .dq_in(dq_in));
    task automatic results();
        $display("mismatches %0d, compares %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wait_for(input bit rd);
        int n;
        n = 0;
        @(negedge clk);
        while ((rd ? rdata_valid_q : req_ready) !== 1'b1) begin
            n++;
            if (n > 200) begin
                error_cnt++;
                results();
            end
            @(negedge clk);
        end
    endtask
    task automatic send(input logic wr, input logic [9:0] a, input logic [3:0] d);
        @(posedge clk);
        req <= {wr, a, d};
        req_valid <= 1'b1;
        wait_for(1'b0);
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [3:0] d);
        send(1'b0, a, 4'h0);
        wait_for(1'b1);
        check(rdata_q, d);
    endtask
    function automatic logic [9:0] adr(input int i);
        return (i == 15) ? 10'h3ff : 10'(i * 67);
    endfunction
    task automatic t_reset();
        @(negedge clk);
        check(pins_q.select_n, 1'b1);
        check(pins_q.dq_oe, 1'b0);
        check(req_ready, 1'b1);
    endtask
    // ------------------------------------------------------------
    // Chained writes over the whole range, then read back
    // ------------------------------------------------------------
    task automatic t_burst();
        for (int i = 0; i < 16; i++) send(1'b1, adr(i), 4'(i));
        for (int i = 0; i < 16; i++) rd_chk(adr(i), 4'(i));
        check(i_mem.fault, 1'b0);
    endtask
    task automatic t_abort();
        send(1'b1, 10'h155, 4'ha);
        repeat (6) @(posedge clk);
        arst_n <= 1'b0;
        @(negedge clk);
        check(pins_q.select_n, 1'b1);
        check(pins_q.dq_oe, 1'b0);
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (200) @(posedge clk);
        rd_chk(adr(3), 4'h3);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_burst();
        t_abort();
        results();
    end
endmodule
bind lsci_host lsci_host_asserts i_chk (.clk(clk), .arst_n(arst_n),
    .rdata_valid_q(rdata_valid_q), .pins_q(pins_q));

// ==== verilog/lsci_host.sv ====
`timescale 1ns/1ps
module lsci_host (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // User request side
    input wire lsci_pkg::lsci_req_t req,
    input wire logic req_valid,
    output logic req_ready,
    output logic [lsci_pkg::DATA_W-1:0] rdata_q,
    output logic rdata_valid_q,
    // Memory pins
    output lsci_pkg::lsci_pins_t pins_q,
    input wire logic [lsci_pkg::DATA_W-1:0] dq_in
);

    // ------------------------------------------------------------
    // Pin input synchroniser
    // ------------------------------------------------------------
    logic [lsci_pkg::DATA_W-1:0] dq_meta_q;
    logic [lsci_pkg::DATA_W-1:0] dq_sync_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_meta_q <= '0;
            dq_sync_q <= '0;
        end else begin
            dq_meta_q <= dq_in;
            dq_sync_q <= dq_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    lsci_pkg::lsci_state_t state_q;
    logic [lsci_pkg::CNT_W-1:0] cnt_q;
    // Select-low time, counted apart from the phase counter
    logic [lsci_pkg::CNT_W-1:0] low_cnt_q;
    lsci_pkg::lsci_req_t cur_q;
    logic next_is_write;
    logic setup_end;
    logic rd_end;
    logic wr_end;
    logic hold_end;

    // True in the last cycle of a phase, so the exit edge lands on the target
    function automatic logic phase_done(input logic [lsci_pkg::CNT_W-1:0] cnt,
                                        input logic [lsci_pkg::CNT_W-1:0] target);
        return (cnt + 6'h01) >= target;
    endfunction

    // Select low must cover both the access time and the minimum low width
    assign setup_end = phase_done(cnt_q, lsci_pkg::ADDR_SETUP_CYC);
    assign rd_end = phase_done(cnt_q, lsci_pkg::READ_SAMPLE_CYC) &&
                    phase_done(low_cnt_q, lsci_pkg::SELECT_LOW_CYC);
    assign wr_end = phase_done(cnt_q, lsci_pkg::DATA_SETUP_CYC) &&
                    phase_done(low_cnt_q, lsci_pkg::SELECT_LOW_CYC);
    assign hold_end = phase_done(cnt_q, lsci_pkg::DATA_HOLD_CYC);

    // Chained write keeps write strobe low between words
    assign next_is_write = req_valid && req.write;
    // Precharge count saturates, so a long pause never drops ready again
    assign req_ready = state_q[0] || (state_q == lsci_pkg::ST_PRECHG &&
                       cnt_q >= lsci_pkg::SELECT_HIGH_CYC - 6'h01);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= lsci_pkg::ST_IDLE;
            cnt_q <= '0;
            low_cnt_q <= '0;
            cur_q <= '0;
        end else begin
            if (cnt_q != '1) begin
                cnt_q <= cnt_q + 6'h01;
            end
            if (low_cnt_q != '1) begin
                low_cnt_q <= low_cnt_q + 6'h01;
            end
            unique case (state_q)
                lsci_pkg::ST_IDLE, lsci_pkg::ST_PRECHG: begin
                    if (req_valid && req_ready) begin
                        cur_q <= req;
                        state_q <= lsci_pkg::ST_ASETUP;
                        cnt_q <= '0;
                    end
                end
                lsci_pkg::ST_ASETUP: begin
                    // Address settled; select falls on leaving this state
                    if (setup_end) begin
                        state_q <= cur_q.write ? lsci_pkg::ST_WR_DATA
                                               : lsci_pkg::ST_RD_LOW;
                        cnt_q <= '0;
                        low_cnt_q <= '0;
                    end
                end
                lsci_pkg::ST_RD_LOW: begin
                    if (rd_end) begin
                        state_q <= lsci_pkg::ST_PRECHG;
                        cnt_q <= '0;
                    end
                end
                lsci_pkg::ST_WR_DATA: begin
                    // Write-first nesting: write already low, data driven
                    if (wr_end) begin
                        state_q <= lsci_pkg::ST_WR_HOLD;
                        cnt_q <= '0;
                    end
                end
                lsci_pkg::ST_WR_HOLD: begin
                    // Select high, data kept through hold, write still low
                    if (hold_end) begin
                        state_q <= lsci_pkg::ST_PRECHG;
                        cnt_q <= '0;
                    end
                end
                lsci_pkg::ST_WR_WAIT: begin
                    // Spare state, never entered; falls back to precharge
                    state_q <= lsci_pkg::ST_PRECHG;
                    cnt_q <= '0;
                end
                default: begin
                    state_q <= lsci_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Pin drivers, all registered
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pins_q.select_n <= 1'b1;
            pins_q.write_n <= 1'b1;
            pins_q.addr <= '0;
            pins_q.dq_out <= '0;
            pins_q.dq_oe <= 1'b0;
        end else begin
            unique case (state_q)
                lsci_pkg::ST_IDLE, lsci_pkg::ST_PRECHG: begin
                    pins_q.select_n <= 1'b1;
                    pins_q.dq_oe <= 1'b0;
                    if (req_valid && req_ready) begin
                        pins_q.addr <= req.addr;
                        // Write strobe falls before select: write-first case
                        pins_q.write_n <= !req.write;
                        pins_q.dq_out <= req.wdata;
                    end else if (!(state_q == lsci_pkg::ST_PRECHG && next_is_write &&
                                   !pins_q.write_n)) begin
                        // Write stays low only while another write is queued
                        pins_q.write_n <= 1'b1;
                    end
                end
                lsci_pkg::ST_ASETUP: begin
                    if (setup_end) begin
                        pins_q.select_n <= 1'b0;
                        // Write already low, so no write-to-data wait is owed
                        pins_q.dq_oe <= cur_q.write;
                    end
                end
                lsci_pkg::ST_RD_LOW: begin
                    pins_q.write_n <= 1'b1;
                    if (rd_end) begin
                        pins_q.select_n <= 1'b1;
                    end
                end
                lsci_pkg::ST_WR_DATA: begin
                    if (wr_end) begin
                        // Select rises before write: late hi-z met
                        pins_q.select_n <= 1'b1;
                    end
                end
                lsci_pkg::ST_WR_HOLD: begin
                    if (hold_end) begin
                        pins_q.dq_oe <= 1'b0;
                    end
                end
                lsci_pkg::ST_WR_WAIT: begin
                    pins_q.dq_oe <= 1'b0;
                end
                default: begin
                    pins_q.select_n <= 1'b1;
                    pins_q.dq_oe <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read return
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= '0;
            rdata_valid_q <= 1'b0;
        end else begin
            rdata_valid_q <= 1'b0;
            // Synchronised word left the pins two cycles ago, at access time
            if (state_q == lsci_pkg::ST_RD_LOW && rd_end) begin
                rdata_q <= dq_sync_q;
                rdata_valid_q <= 1'b1;
            end
        end
    end

endmodule

// ==== verilog/lsci_pkg.sv ====
package lsci_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 4;
    localparam int WORDS = 1024;

    // ------------------------------------------------------------
    // Timing (ns, fastest speed grade) and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int SELECT_LOW_MIN_NS = 120;
    localparam int SELECT_HIGH_MIN_WIDTH_NS = 50;
    localparam int ADDR_SETUP_NS = 0;
    localparam int ADDR_HOLD_NS = 40;
    localparam int READ_ACCESS_NS = 120;
    localparam int WRITE_TO_DATA_DELAY_NS = 70;
    localparam int DATA_SETUP_TO_SELECT_RISE_NS = 50;
    localparam int DATA_HOLD_AFTER_SELECT_RISE_NS = 0;
    localparam int SELECT_RISE_TO_OUTPUT_OFF_NS = 50;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] SELECT_LOW_CYC = CNT_W'(ns_to_cyc(SELECT_LOW_MIN_NS));
    localparam logic [CNT_W-1:0] SELECT_HIGH_CYC = CNT_W'(ns_to_cyc(SELECT_HIGH_MIN_WIDTH_NS));
    localparam logic [CNT_W-1:0] ADDR_SETUP_CYC = CNT_W'(ns_to_cyc(ADDR_SETUP_NS));
    localparam logic [CNT_W-1:0] ADDR_HOLD_CYC = CNT_W'(ns_to_cyc(ADDR_HOLD_NS));
    // Sample at the access time, plus the synchroniser delay
    localparam logic [CNT_W-1:0] READ_SAMPLE_CYC = CNT_W'(ns_to_cyc(READ_ACCESS_NS) + 2);
    localparam logic [CNT_W-1:0] WR_DATA_DELAY_CYC =
        CNT_W'(ns_to_cyc(WRITE_TO_DATA_DELAY_NS));
    localparam logic [CNT_W-1:0] DATA_SETUP_CYC =
        CNT_W'(ns_to_cyc(DATA_SETUP_TO_SELECT_RISE_NS));
    localparam logic [CNT_W-1:0] DATA_HOLD_CYC =
        CNT_W'(ns_to_cyc(DATA_HOLD_AFTER_SELECT_RISE_NS));
    localparam logic [CNT_W-1:0] OUTPUT_OFF_CYC =
        CNT_W'(ns_to_cyc(SELECT_RISE_TO_OUTPUT_OFF_NS));

    // ------------------------------------------------------------
    // Carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } lsci_req_t;

    typedef struct packed {
        logic select_n;
        logic write_n;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } lsci_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ASETUP = 7'h02,
        ST_RD_LOW = 7'h04,
        ST_WR_WAIT = 7'h08,
        ST_WR_DATA = 7'h10,
        ST_WR_HOLD = 7'h20,
        ST_PRECHG = 7'h40
    } lsci_state_t;

endpackage
